// file: verilog/bcrtc_top.v
// What this block does
// - Seconds count BCD 00 to 59, wrap carries into minutes.
// - Minutes count BCD 00 to 59, wrap carries into hours.
// - Hours count 00 to 23; wrap advances date and weekday.
// - Weekday counts 01 to 07, then back to 01.
// - Date wraps after 31, 30, 29 or 28 per month and leap year.
// - Month counts 1 to 12, wrap carries into the year.
// - Year counts 00 to 99; multiples of four are leap years.
// - All time values are packed BCD on reads and writes.
// - Halt bit in seconds bit 7 stops oscillator and chain; resets 0.
// - Hours bits 7 and 6 are century enable and flag, reset 1.
// - Both lines are only pulled low or released.
// - Start and repeated start are data falling, stop data rising, clock high.
// - Data changes while clock low, sampled while clock high.
// - Bytes are eight bits with no limit before the stop.
// - Register pointer advances by one after each data byte.
// - Transmitter releases data after the eighth bit; receiver acknowledges.
// - After master acknowledge, release at ninth clock fall and keep sending.
// - Missing master acknowledge ends the read; wait for stop.
// - Respond only to slave address byte D0h write or D1h read.
// - Only six pointer bits are decoded, higher pointers alias.
`timescale 1ns/10ps
`default_nettype none
`include "bcrtc_map.vh"

module bcrtc_top #(
    parameter OSC_PER_SEC = `BCRTC_OSC_PER_SEC
) (
    input  wire clock,
    input  wire srst,
    input  wire osc_clk,
    input  wire scl_in,
    input  wire sda_in,
    output reg  sda_out_ff,
    output reg  sda_oe_ff,
    output reg  osc_enable_ff
);

    localparam ST_IDLE = 3'h0;
    localparam ST_RX   = 3'h1;
    localparam ST_ACK  = 3'h2;
    localparam ST_TX   = 3'h3;
    localparam ST_MACK = 3'h4;
    localparam ST_WAIT = 3'h5;

    // Three-stage synchronisers and filtered levels of the pins.
    reg [2:0]  osc_sync_ff;
    reg [2:0]  scl_sync_ff;
    reg [2:0]  sda_sync_ff;
    reg        osc_f_ff;
    reg        osc_d_ff;
    reg        scl_f_ff;
    reg        scl_d_ff;
    reg        sda_f_ff;
    reg        sda_d_ff;

    // Time and calendar registers.
    reg        halt_ff;
    reg [6:0]  sec_ff;
    reg [6:0]  min_ff;
    reg        ceb_ff;
    reg        cb_ff;
    reg [5:0]  hour_ff;
    reg [2:0]  wday_ff;
    reg [5:0]  date_ff;
    reg [4:0]  mon_ff;
    reg [7:0]  year_ff;
    reg [15:0] presc_ff;
    reg        step_ff;

    // Bus engine state.
    reg [2:0]  state_ff;
    reg [1:0]  kind_ff;
    reg [3:0]  cnt_ff;
    reg [7:0]  shift_ff;
    reg [7:0]  tx_ff;
    reg        rw_ff;
    reg        mack_ff;
    reg [5:0]  ptr_ff;
    reg        push_ff;
    reg [13:0] push_data_ff;

    wire        scl_rise;
    wire        scl_fall;
    wire        start_cond;
    wire        stop_cond;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire        fifo_out_ready;
    wire [13:0] fifo_out_data;
    wire [5:0]  wr_addr;
    wire [7:0]  wr_data;
    wire        leap;
    reg  [7:0]  month_len;
    reg  [7:0]  rd_byte;

    // BCD increment of one field, wrapping from the top value to the bottom one.
    function [7:0] bcd_inc;
        input [7:0] val;
        input [7:0] top;
        input [7:0] bottom;
        begin
            if (val == top) begin
                bcd_inc = bottom;
            end else if (val[3:0] == `BCRTC_UNIT_NINE) begin
                bcd_inc = {val[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = val + 8'h01;
            end
        end
    endfunction

    // Next BCD value of each field; the unused top bits are dropped where it is stored.
    wire [7:0]  nxt_sec  = bcd_inc({1'b0, sec_ff}, `BCRTC_SEC_MAX, `BCRTC_ZERO_BCD);
    wire [7:0]  nxt_min  = bcd_inc({1'b0, min_ff}, `BCRTC_SEC_MAX, `BCRTC_ZERO_BCD);
    wire [7:0]  nxt_hour = bcd_inc({2'h0, hour_ff}, `BCRTC_HOUR_MAX, `BCRTC_ZERO_BCD);
    wire [7:0]  nxt_wday = bcd_inc({5'h0, wday_ff}, `BCRTC_WDAY_MAX, `BCRTC_WDAY_MIN);
    wire [7:0]  nxt_date = bcd_inc({2'h0, date_ff}, month_len, `BCRTC_DATE_MIN);
    wire [7:0]  nxt_mon  = bcd_inc({3'h0, mon_ff}, `BCRTC_MONTH_MAX, `BCRTC_DATE_MIN);

    // Synchronisers: the first stage feeds only the second; a level is
    // accepted once the second and third stages agree.
    always @(posedge clock) begin
        if (srst) begin
            osc_sync_ff <= 3'h0;
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            osc_f_ff    <= 1'b0;
            osc_d_ff    <= 1'b0;
            scl_f_ff    <= 1'b1;
            scl_d_ff    <= 1'b1;
            sda_f_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end else begin
            osc_sync_ff <= {osc_sync_ff[1:0], osc_clk};
            scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
            if (osc_sync_ff[1] == osc_sync_ff[2]) begin
                osc_f_ff <= osc_sync_ff[2];
            end
            if (scl_sync_ff[1] == scl_sync_ff[2]) begin
                scl_f_ff <= scl_sync_ff[2];
            end
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_f_ff <= sda_sync_ff[2];
            end
            osc_d_ff <= osc_f_ff;
            scl_d_ff <= scl_f_ff;
            sda_d_ff <= sda_f_ff;
        end
    end

    // Bus conditions: data edges while the clock stays high.
    assign scl_rise   = scl_f_ff && !scl_d_ff;
    assign scl_fall   = !scl_f_ff && scl_d_ff;
    assign start_cond = scl_f_ff && scl_d_ff && sda_d_ff && !sda_f_ff;
    assign stop_cond  = scl_f_ff && scl_d_ff && !sda_d_ff && sda_f_ff;

    // Second prescaler; it freezes together with the chain while halted.
    always @(posedge clock) begin
        if (srst) begin
            presc_ff      <= 16'h0000;
            step_ff       <= 1'b0;
            osc_enable_ff <= 1'b1;
        end else begin
            osc_enable_ff <= !halt_ff;
            step_ff       <= 1'b0;
            if (!halt_ff && osc_f_ff && !osc_d_ff) begin
                if (presc_ff == OSC_PER_SEC[15:0] - 16'h0001) begin
                    presc_ff <= 16'h0000;
                    step_ff  <= 1'b1;
                end else begin
                    presc_ff <= presc_ff + 16'h0001;
                end
            end
        end
    end

    // Leap year from the BCD year: even tens need units 0,4,8, odd tens 2,6.
    assign leap = year_ff[4] ? (year_ff[1:0] == `BCRTC_LEAP_ODD_TENS)
                             : (year_ff[1:0] == `BCRTC_LEAP_EVEN_TENS);

    // Last date of the current month.
    always @* begin
        case ({3'h0, mon_ff})
            `BCRTC_FEB: month_len = leap ? `BCRTC_DAYS_29 : `BCRTC_DAYS_28;
            `BCRTC_APR,
            `BCRTC_JUN,
            `BCRTC_SEP,
            `BCRTC_NOV: month_len = `BCRTC_DAYS_30;
            default:    month_len = `BCRTC_DAYS_31;
        endcase
    end

    // Writes from the bus wait in the FIFO; draining pauses on a count step.
    assign fifo_out_ready = !step_ff;
    assign wr_addr        = fifo_out_data[13:8];
    assign wr_data        = fifo_out_data[7:0];

    // Counter chain and register writes; a step and a write never coincide.
    always @(posedge clock) begin
        if (srst) begin
            halt_ff <= `BCRTC_HALT_RST;
            ceb_ff  <= `BCRTC_CEB_RST;
            cb_ff   <= `BCRTC_CB_RST;
            sec_ff  <= 7'h00;
            min_ff  <= 7'h00;
            hour_ff <= 6'h00;
            wday_ff <= 3'h1;
            date_ff <= 6'h01;
            mon_ff  <= 5'h01;
            year_ff <= 8'h00;
        end else if (step_ff) begin
            sec_ff <= nxt_sec[6:0];
            if ({1'b0, sec_ff} == `BCRTC_SEC_MAX) begin
                min_ff <= nxt_min[6:0];
                if ({1'b0, min_ff} == `BCRTC_SEC_MAX) begin
                    hour_ff <= nxt_hour[5:0];
                    if ({2'h0, hour_ff} == `BCRTC_HOUR_MAX) begin
                        wday_ff <= nxt_wday[2:0];
                        date_ff <= nxt_date[5:0];
                        if ({2'h0, date_ff} == month_len) begin
                            mon_ff <= nxt_mon[4:0];
                            if ({3'h0, mon_ff} == `BCRTC_MONTH_MAX) begin
                                year_ff <= bcd_inc(year_ff, `BCRTC_YEAR_MAX,
                                                   `BCRTC_ZERO_BCD);
                                if (year_ff == `BCRTC_YEAR_MAX && ceb_ff) begin
                                    cb_ff <= !cb_ff;
                                end
                            end
                        end
                    end
                end
            end
        end else if (fifo_out_valid) begin
            // Stored as received: packed BCD, unused bits dropped.
            case (wr_addr)
                `BCRTC_ADDR_SECONDS: begin
                    halt_ff <= wr_data[7];
                    sec_ff  <= wr_data[6:0];
                end
                `BCRTC_ADDR_MINUTES: min_ff <= wr_data[6:0];
                `BCRTC_ADDR_HOURS: begin
                    ceb_ff  <= wr_data[7];
                    cb_ff   <= wr_data[6];
                    hour_ff <= wr_data[5:0];
                end
                `BCRTC_ADDR_WEEKDAY: wday_ff <= wr_data[2:0];
                `BCRTC_ADDR_DATE:    date_ff <= wr_data[5:0];
                `BCRTC_ADDR_MONTH:   mon_ff  <= wr_data[4:0];
                `BCRTC_ADDR_YEAR:    year_ff <= wr_data;
                default: begin
                    halt_ff <= halt_ff;
                end
            endcase
        end
    end

    // Read view of the register at the pointer; unused bits read zero.
    always @* begin
        case (ptr_ff)
            `BCRTC_ADDR_SECONDS: rd_byte = {halt_ff, sec_ff};
            `BCRTC_ADDR_MINUTES: rd_byte = {1'b0, min_ff};
            `BCRTC_ADDR_HOURS:   rd_byte = {ceb_ff, cb_ff, hour_ff};
            `BCRTC_ADDR_WEEKDAY: rd_byte = {5'h00, wday_ff};
            `BCRTC_ADDR_DATE:    rd_byte = {2'h0, date_ff};
            `BCRTC_ADDR_MONTH:   rd_byte = {3'h0, mon_ff};
            `BCRTC_ADDR_YEAR:    rd_byte = year_ff;
            default:             rd_byte = 8'h00;
        endcase
    end

    // Slave byte engine: receive, acknowledge, transmit, wait for stop.
    always @(posedge clock) begin
        if (srst) begin
            state_ff     <= ST_IDLE;
            kind_ff      <= `BCRTC_KIND_ADDR;
            cnt_ff       <= 4'h0;
            shift_ff     <= 8'h00;
            tx_ff        <= 8'h00;
            rw_ff        <= 1'b0;
            mack_ff      <= 1'b0;
            ptr_ff       <= 6'h00;
            push_ff      <= 1'b0;
            push_data_ff <= 14'h0000;
            sda_out_ff   <= 1'b0;
            sda_oe_ff    <= 1'b0;
        end else begin
            push_ff    <= 1'b0;
            sda_out_ff <= 1'b0;
            if (start_cond) begin
                state_ff  <= ST_RX;
                kind_ff   <= `BCRTC_KIND_ADDR;
                cnt_ff    <= 4'h0;
                sda_oe_ff <= 1'b0;
            end else if (stop_cond) begin
                state_ff  <= ST_IDLE;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_f_ff};
                            cnt_ff   <= cnt_ff + 4'h1;
                        end else if (scl_fall && cnt_ff == `BCRTC_BIT_LAST) begin
                            cnt_ff <= 4'h0;
                            if (kind_ff == `BCRTC_KIND_ADDR) begin
                                if (shift_ff[7:1] == `BCRTC_SLAVE_ADDR) begin
                                    rw_ff     <= shift_ff[0];
                                    kind_ff   <= `BCRTC_KIND_PTR;
                                    sda_oe_ff <= 1'b1;
                                    state_ff  <= ST_ACK;
                                end else begin
                                    state_ff <= ST_WAIT;
                                end
                            end else if (kind_ff == `BCRTC_KIND_PTR) begin
                                ptr_ff    <= shift_ff[5:0];
                                kind_ff   <= `BCRTC_KIND_DATA;
                                sda_oe_ff <= 1'b1;
                                state_ff  <= ST_ACK;
                            end else if (fifo_in_ready) begin
                                push_ff      <= 1'b1;
                                push_data_ff <= {ptr_ff, shift_ff};
                                ptr_ff       <= ptr_ff + `BCRTC_PTR_STEP;
                                sda_oe_ff    <= 1'b1;
                                state_ff     <= ST_ACK;
                            end else begin
                                state_ff <= ST_WAIT;
                            end
                        end
                    end
                    ST_ACK, ST_MACK: begin
                        if (scl_rise) begin
                            mack_ff <= !sda_f_ff;
                        end else if (scl_fall) begin
                            if (rw_ff && (state_ff == ST_ACK || mack_ff)) begin
                                tx_ff     <= rd_byte;
                                sda_oe_ff <= !rd_byte[7];
                                ptr_ff    <= ptr_ff + `BCRTC_PTR_STEP;
                                cnt_ff    <= 4'h0;
                                state_ff  <= ST_TX;
                            end else if (rw_ff) begin
                                sda_oe_ff <= 1'b0;
                                state_ff  <= ST_WAIT;
                            end else begin
                                sda_oe_ff <= 1'b0;
                                state_ff  <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            cnt_ff <= cnt_ff + 4'h1;
                            if (cnt_ff == `BCRTC_TX_LAST) begin
                                sda_oe_ff <= 1'b0;
                                state_ff  <= ST_MACK;
                            end else begin
                                tx_ff     <= {tx_ff[6:0], 1'b0};
                                sda_oe_ff <= !tx_ff[6];
                            end
                        end
                    end
                    ST_WAIT: begin
                        sda_oe_ff <= 1'b0;
                    end
                    default: begin
                        sda_oe_ff <= 1'b0;
                        state_ff  <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Write FIFO between the bus side and the register file.
    bcrtc_fifo #(
        .WIDTH (`BCRTC_FIFO_WIDTH),
        .DEPTH (`BCRTC_FIFO_DEPTH),
        .AW    (`BCRTC_FIFO_AW)
    ) u_wr_fifo (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (push_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_ff),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

endmodule

`default_nettype wire

// file: verilog/bcrtc_map.vh
`ifndef BCRTC_MAP_VH
`define BCRTC_MAP_VH

// Register pointer values; only six pointer bits are decoded.
`define BCRTC_PTR_W          6
`define BCRTC_ADDR_SECONDS   6'h00
`define BCRTC_ADDR_MINUTES   6'h01
`define BCRTC_ADDR_HOURS     6'h02
`define BCRTC_ADDR_WEEKDAY   6'h03
`define BCRTC_ADDR_DATE      6'h04
`define BCRTC_ADDR_MONTH     6'h05
`define BCRTC_ADDR_YEAR      6'h06
`define BCRTC_PTR_STEP       6'h01

// Fixed 7-bit slave address; the first byte reads D0h for write, D1h for read.
`define BCRTC_SLAVE_ADDR     7'h68

// Reset values of the control bits held in the time registers.
`define BCRTC_HALT_RST       1'h0
`define BCRTC_CEB_RST        1'h1
`define BCRTC_CB_RST         1'h1

// BCD limits of the counter chain.
`define BCRTC_SEC_MAX        8'h59
`define BCRTC_HOUR_MAX       8'h23
`define BCRTC_WDAY_MIN       8'h01
`define BCRTC_WDAY_MAX       8'h07
`define BCRTC_DATE_MIN       8'h01
`define BCRTC_MONTH_MAX      8'h12
`define BCRTC_YEAR_MAX       8'h99
`define BCRTC_ZERO_BCD       8'h00
`define BCRTC_DAYS_31        8'h31
`define BCRTC_DAYS_30        8'h30
`define BCRTC_DAYS_29        8'h29
`define BCRTC_DAYS_28        8'h28
`define BCRTC_FEB            8'h02
`define BCRTC_APR            8'h04
`define BCRTC_JUN            8'h06
`define BCRTC_SEP            8'h09
`define BCRTC_NOV            8'h11
`define BCRTC_UNIT_NINE      4'h9
`define BCRTC_LEAP_EVEN_TENS 2'h0
`define BCRTC_LEAP_ODD_TENS  2'h2

// Oscillator rising edges per second.
`define BCRTC_OSC_PER_SEC    32768

// Bus byte engine.
`define BCRTC_BIT_LAST       4'h8
`define BCRTC_TX_LAST        4'h7
`define BCRTC_KIND_ADDR      2'h0
`define BCRTC_KIND_PTR       2'h1
`define BCRTC_KIND_DATA      2'h2

// Write FIFO shape: pointer plus data byte, sixteen entries.
`define BCRTC_FIFO_WIDTH     14
`define BCRTC_FIFO_DEPTH     16
`define BCRTC_FIFO_AW        4

`endif

// file: verilog/bcrtc_fifo.v
`timescale 1ns/10ps
`default_nettype none

module bcrtc_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock,
    input  wire             srst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;
    wire [AW:0]     used;
    wire            do_push;
    wire            do_load;

    // Memory fill level; the output register is an extra stage on top.
    assign used     = wr_ptr_ff - rd_ptr_ff;
    assign in_ready = (used != DEPTH[AW:0]);
    assign do_push  = in_valid && in_ready;
    assign do_load  = (used != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    // Storage array written on every accepted word.
    always @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    // Pointers and the registered read port.
    always @(posedge clock) begin
        if (srst) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_load) begin
                out_data  <= mem[rd_ptr_ff[AW-1:0]];
                out_valid <= 1'b1;
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: testbench/bcrtc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module bcrtc_checker #(
    parameter OSC_PER_SEC = 32768
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic osc_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out_ff,
    input wire logic sda_oe_ff,
    input wire logic osc_enable_ff
);
    logic [7:0] oe_run_ff;
    // Counts how long the data line has been held low without a break.
    always_ff @(posedge clock) begin
        if (srst || !sda_oe_ff) oe_run_ff <= 8'h00;
        else if (oe_run_ff != 8'hFF) oe_run_ff <= oe_run_ff + 8'h01;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    out_low_a: assert property (!sda_out_ff) else $error("data pin driven high");
    reset_idle_a: assert property ($fell(srst) |-> osc_enable_ff && !sda_oe_ff)
        else $error("bad state after reset");
    oe_steady_a: assert property (scl_in [*4] |-> $stable(sda_oe_ff))
        else $error("data moved while clock high");
    oe_move_a: assert property ($changed(sda_oe_ff) |-> !$past(scl_in, 2))
        else $error("data moved too late after clock fall");
    oe_hold_a: assert property ($rose(sda_oe_ff) |-> sda_oe_ff [*8])
        else $error("low pulse too short");
    oe_bound_a: assert property (oe_run_ff < 8'h50) else $error("line held too long");
    stop_quiet_a: assert property (scl_in && $rose(sda_in) |-> !sda_oe_ff [*8])
        else $error("line driven after stop");
    release_low_a: assert property ($fell(sda_oe_ff) |-> !scl_in)
        else $error("release while clock high");
    cover property ($rose(sda_oe_ff));
    cover property ($fell(osc_enable_ff));
    cover property (oe_run_ff > 8'h40);
    cover property ($rose(osc_clk) && !osc_enable_ff);
endmodule
`default_nettype wire

// file: testbench/bcrtc_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
module bcrtc_i2c_master (
    input  wire logic clock,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_oe
);
    // The bus idles released, clock high.
    initial scl = 1'b1;
    initial sda_oe = 1'b0;
    // Waits whole system clock cycles.
    task automatic hw(input int n);
        repeat (n) @(posedge clock);
    endtask
    // One 400 ns bit: six cycles low so the slave can answer, then two high.
    task automatic bx(input logic b, output logic r);
        scl <= 1'b0;
        hw(2);
        sda_oe <= !b;
        hw(4);
        scl <= 1'b1;
        hw(1);
        r = sda;
        hw(1);
    endtask
    // Start when stop is low, stop when high; the low phase is skipped from idle.
    task automatic cond(input logic stop);
        if (stop || sda !== 1'b1) begin
            scl <= 1'b0;
            hw(2);
            sda_oe <= stop;
            hw(6);
            scl <= 1'b1;
            hw(8);
        end
        sda_oe <= !stop;
        hw(8);
    endtask
    // Start or repeated start, and stop, as the bench calls them.
    task automatic begin_xfer();
        cond(1'b0);
    endtask
    task automatic end_xfer();
        cond(1'b1);
    endtask
    // Eight bits MSB first plus the acknowledge bit; a one releases the line.
    task automatic byte9(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bx(d[i], q[i]);
    endtask
endmodule
`default_nettype wire

// file: testbench/bcrtc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bcrtc_top_tb;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic       osc_clk = 1'b0;
    wire  logic scl;
    wire  logic m_oe;
    wire  logic d_oe;
    wire  logic d_out;
    wire  logic osc_en;
    wire  logic sda;
    int         fails = 0;
    int         comparisons = 0;
    logic [8:0] q;
    // Pulled-up data line shared by both parties.
    assign sda = !m_oe && (d_oe ? d_out : 1'b1);
    bcrtc_i2c_master i_m (.clock(clock), .sda(sda), .scl(scl), .sda_oe(m_oe));
    bcrtc_top #(.OSC_PER_SEC(4)) i_dut (.clock(clock), .srst(srst), .osc_clk(osc_clk),
        .scl_in(scl), .sda_in(sda), .sda_out_ff(d_out), .sda_oe_ff(d_oe),
        .osc_enable_ff(osc_en));
    // System clock.
    initial forever #25 clock = ~clock;
    // Compares and counts.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Writes n bytes from the low end of v starting at pointer p.
    task automatic wr(input logic [7:0] p, input logic [55:0] v, input int n);
        i_m.begin_xfer();
        i_m.byte9({8'hD0, 1'b1}, q);
        chk({7'h00, q[0]}, 8'h00);
        i_m.byte9({p, 1'b1}, q);
        for (int i = 0; i < n; i++) i_m.byte9({v[8*i+:8], 1'b1}, q);
        chk({7'h00, q[0]}, 8'h00);
        i_m.end_xfer();
    endtask
    // Reads n bytes, setting the pointer first when s is high.
    task automatic rd(input logic s, input logic [7:0] p, input logic [55:0] e, input int n);
        if (s) begin
            i_m.begin_xfer();
            i_m.byte9({8'hD0, 1'b1}, q);
            i_m.byte9({p, 1'b1}, q);
        end
        i_m.begin_xfer();
        i_m.byte9({8'hD1, 1'b1}, q);
        chk({7'h00, q[0]}, 8'h00);
        for (int i = 0; i < n; i++) begin
            i_m.byte9({8'hFF, i == n - 1}, q);
            chk(q[8:1], e[8*i+:8]);
        end
        i_m.end_xfer();
    endtask
    // Gives n oscillator rising edges.
    task automatic tick(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge clock);
            osc_clk <= !osc_clk;
        end
    endtask
    // Loads a halted time, checks it stays frozen, then runs exactly one second.
    task automatic roll(input logic [55:0] s, input logic [55:0] e);
        wr(8'h00, s, 7);
        chk({7'h00, osc_en}, 8'h00);
        tick(4);
        wr(8'h00, {48'h0, s[7:0] & 8'h7F}, 1);
        chk({7'h00, osc_en}, 8'h01);
        tick(4);
        rd(1'b1, 8'h00, e, 7);
    endtask
    // Closing report.
    task automatic test_done();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge clock);
        fails++;
        test_done();
    end
    // Main sequence.
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        repeat (6) @(posedge clock);
        chk({6'h00, osc_en, d_oe}, 8'h02);
        rd(1'b1, 8'h00, 56'h00_01_01_01_C0_00_00, 7);
        $display("reset values done");
        i_m.begin_xfer();
        i_m.byte9({8'hD2, 1'b1}, q);
        i_m.end_xfer();
        chk({7'h00, q[0]}, 8'h01);
        $display("foreign address done");
        roll(56'h99_12_31_07_E3_59_D9, 56'h00_01_01_01_80_00_00);
        roll(56'h99_02_28_01_23_59_D9, 56'h99_03_01_02_00_00_00);
        roll(56'h04_02_28_03_23_59_D9, 56'h04_02_29_04_00_00_00);
        roll(56'h05_04_30_06_63_59_D9, 56'h05_05_01_07_40_00_00);
        roll(56'h99_12_31_02_63_59_D9, 56'h00_01_01_03_40_00_00);
        $display("rollover done");
        wr(8'h41, 56'h37, 1);
        rd(1'b0, 8'h00, 56'h40, 1);
        rd(1'b1, 8'h01, 56'h37, 1);
        wr(8'h07, 56'h5A, 1);
        rd(1'b1, 8'h07, 56'h00, 1);
        $display("pointer done");
        test_done();
    end
endmodule
bind bcrtc_top bcrtc_checker #(.OSC_PER_SEC(OSC_PER_SEC)) i_chk (.clock(clock), .srst(srst),
    .osc_clk(osc_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff), .osc_enable_ff(osc_enable_ff));
`default_nettype wire
